// [wbl_pkg.sv]
// Package of constants for the colour balance lookup stage
package wbl_pkg;
  // Register window offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h2A;
  // Control register field positions
  localparam int PAGE_HI = 7;
  localparam int PAGE_LO = 6;
  localparam int ENABLE_BIT = 5;
  localparam int RELOAD_BIT = 4;
  // Control register value after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Page codes
  localparam logic [1:0] PAGE_CONFIG = 2'h0;
  localparam logic [1:0] PAGE_RED = 2'h1;
  localparam logic [1:0] PAGE_GREEN = 2'h2;
  localparam logic [1:0] PAGE_BLUE = 2'h3;
  // Table geometry
  localparam int TABLE_DEPTH = 256;
  localparam int TABLE_WIDTH = 8;
  // Fixed latency of the lookup pipeline in pixel clocks
  localparam int LOOKUP_LATENCY = 2;
  // Pixel FIFO depth
  localparam int FIFO_DEPTH = 8;
  // Load progress states, one-hot
  typedef enum logic [3:0] {
    LOAD_RED = 4'h1,
    LOAD_GREEN = 4'h2,
    LOAD_BLUE = 4'h4,
    LOAD_DONE = 4'h8
  } wbl_load_type;
endpackage

// [wbl_fifo.sv]
// Small synchronous FIFO carrying pixels into the lookup stage
`timescale 1ns/100ps
`default_nettype none
module wbl_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);

  // Refuse depths that are not a power of two
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("wbl_fifo depth must be a power of two");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW:0] wr_ptr;  // Write pointer with wrap bit
  logic [AW:0] rd_ptr;  // Read pointer with wrap bit
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign o_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign o_valid = wr_ptr != rd_ptr;
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem[rd_ptr[AW-1:0]];

  // Storage write; no reset needed on data
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end

  // Pointers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [wbl_top.sv]
// Colour balance lookup stage with host register window
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Three 256 by 8 bit colour tables
// - Host reads and writes every table entry
// - Control bits 7:6 select the page
// - On table pages address equals entry index
// - Bit 5 enables remapping, else passthrough
// - No table writes after initial load
// - Bit 4 permits later table reloads
// - Reload while enabled applies each entry as it is written
// - Partial reloads keep other entries
module wbl_top (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // Host register port
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  output logic O_REG_RVALID,
  output logic O_LOAD_DONE,
  // Incoming pixels
  input wire logic I_PIX_VALID,
  output logic O_PIX_READY,
  input wire logic [7:0] I_RED,
  input wire logic [7:0] I_GREEN,
  input wire logic [7:0] I_BLUE,
  input wire logic I_HSYNC,
  input wire logic I_VSYNC,
  input wire logic I_DE,
  // Outgoing pixels
  output logic O_PIX_VALID,
  input wire logic I_PIX_READY,
  output logic [7:0] O_RED,
  output logic [7:0] O_GREEN,
  output logic [7:0] O_BLUE,
  output logic O_HSYNC,
  output logic O_VSYNC,
  output logic O_DE
);
  localparam int PW = 27;  // Pixel word: three colours and three controls

  logic [7:0] ctrl;  // Control register
  wbl_pkg::wbl_load_type load_state;  // Initial load progress
  logic [7:0] table_mem [3][wbl_pkg::TABLE_DEPTH];
  logic [1:0] page;  // Page currently shown in the register window
  logic on_table;  // Access falls into a table page
  logic [1:0] tsel;  // Table index 0..2
  logic write_ok;  // Table writes are currently accepted
  logic last_entry;  // Access to index 255
  logic table_wr;  // Table write that is accepted this cycle
  logic page_back;  // Any write to a last entry returns the window to page zero
  logic f_valid;  // FIFO holds a pixel for stage one
  logic f_ready;  // Stage one takes the FIFO head
  logic [PW-1:0] f_data;  // FIFO head: syncs in the top bits, then red, green, blue
  logic adv;  // Pipeline advances
  logic [PW-1:0] s1;  // Stage one pixel
  logic s1_valid;  // Stage one holds a real pixel, not a bubble

  // Refuse package settings the logic cannot serve: the window address is eight bits wide,
  // and the two register stages below are the whole lookup latency
  if (wbl_pkg::TABLE_DEPTH != 256 || wbl_pkg::TABLE_WIDTH != 8) begin : g_table_check
    $error("wbl_top tables must be 256 entries of 8 bits");
  end
  if (wbl_pkg::LOOKUP_LATENCY != 2) begin : g_latency_check
    $error("wbl_top lookup pipeline has exactly two stages");
  end

  // Window decode; the table index is the page code less one
  assign page = ctrl[wbl_pkg::PAGE_HI:wbl_pkg::PAGE_LO];
  assign on_table = page != wbl_pkg::PAGE_CONFIG;
  assign tsel = page - 2'h1;
  assign last_entry = I_REG_ADDR == 8'hFF;
  // Write qualifiers shared by the table, the load tracker and the page return
  assign table_wr = I_REG_WR && on_table && write_ok;
  assign page_back = I_REG_WR && on_table && last_entry;
  assign O_LOAD_DONE = load_state == wbl_pkg::LOAD_DONE;

  // Writes open while loading in order, or after load when reload is permitted
  always_comb begin
    case (load_state)
      wbl_pkg::LOAD_RED: write_ok = page == wbl_pkg::PAGE_RED;
      wbl_pkg::LOAD_GREEN: write_ok = page == wbl_pkg::PAGE_GREEN;
      wbl_pkg::LOAD_BLUE: write_ok = page == wbl_pkg::PAGE_BLUE;
      default: write_ok = ctrl[wbl_pkg::RELOAD_BIT];
    endcase
  end

  // Control register, reachable on page zero only; reserved bits stay zero.
  // A table page shadows address 0x2A, so any write to a table's last entry hands the
  // window back to page zero. A host that only reads a table must end with that write.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl <= wbl_pkg::CTRL_RESET;
    end else if (I_REG_WR && I_REG_ADDR == wbl_pkg::CTRL_OFFSET && !on_table) begin
      ctrl <= {I_REG_WDATA[7:4], 4'h0};
    end else if (page_back) begin
      // Refused writes return the page too, so the host can never be locked out
      ctrl[wbl_pkg::PAGE_HI:wbl_pkg::PAGE_LO] <= wbl_pkg::PAGE_CONFIG;
    end
  end

  // Load progress advances when the last entry of the expected table lands.
  // Entries 0..254 may arrive in any order; only the accepted last entry moves on.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      load_state <= wbl_pkg::LOAD_RED;
    end else if (table_wr && last_entry) begin
      case (load_state)
        wbl_pkg::LOAD_RED: load_state <= wbl_pkg::LOAD_GREEN;
        wbl_pkg::LOAD_GREEN: load_state <= wbl_pkg::LOAD_BLUE;
        wbl_pkg::LOAD_BLUE: load_state <= wbl_pkg::LOAD_DONE;
        default: load_state <= wbl_pkg::LOAD_DONE;
      endcase
    end
  end

  // Table write; only the addressed entry changes.
  // No reset: contents are undefined until the host loads them.
  always_ff @(posedge I_CORE_CLK) begin
    if (table_wr) begin
      table_mem[tsel][I_REG_ADDR] <= I_REG_WDATA;
    end
  end

  // Register read answers one cycle after the strobe.
  // Read data holds between reads; tables stay readable whatever the load state.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_REG_RDATA <= 8'h00;
      O_REG_RVALID <= 1'b0;
    end else begin
      O_REG_RVALID <= I_REG_RD;
      if (I_REG_RD) begin
        if (on_table) begin
          O_REG_RDATA <= table_mem[tsel][I_REG_ADDR];
        end else if (I_REG_ADDR == wbl_pkg::CTRL_OFFSET) begin
          O_REG_RDATA <= ctrl;
        end else begin
          // Unmapped configuration addresses read zero
          O_REG_RDATA <= 8'h00;
        end
      end
    end
  end

  // Input buffer absorbs stalls from the panel side
  wbl_fifo #(.WIDTH(PW), .DEPTH(wbl_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_valid(I_PIX_VALID),
    .o_ready(O_PIX_READY),
    .i_data({I_HSYNC, I_VSYNC, I_DE, I_RED, I_GREEN, I_BLUE}),
    .o_valid(f_valid),
    .i_ready(f_ready),
    .o_data(f_data)
  );

  // Two-stage pipeline stalls as a whole, keeping colours and syncs aligned.
  // Trade-off: a stalled output also holds stage one, so a bubble is not squeezed out,
  // but the logic stays small and the latency is fixed.
  assign adv = !O_PIX_VALID || I_PIX_READY;
  assign f_ready = adv;

  // Stage one: register the pixel
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      s1 <= '0;
      s1_valid <= 1'b0;
    end else if (adv) begin
      s1 <= f_data;
      s1_valid <= f_valid;
    end
  end

  // Stage two: lookup; table read each pixel so a reload takes effect per pixel.
  // The enable bit is sampled here, so a change applies from the next pixel on.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PIX_VALID <= 1'b0;
      {O_HSYNC, O_VSYNC, O_DE} <= 3'h0;
      O_RED <= 8'h00;
      O_GREEN <= 8'h00;
      O_BLUE <= 8'h00;
    end else if (adv) begin
      O_PIX_VALID <= s1_valid;
      {O_HSYNC, O_VSYNC, O_DE} <= s1[26:24];
      if (ctrl[wbl_pkg::ENABLE_BIT]) begin
        O_RED <= table_mem[0][s1[23:16]];
        O_GREEN <= table_mem[1][s1[15:8]];
        O_BLUE <= table_mem[2][s1[7:0]];
      end else begin
        O_RED <= s1[23:16];
        O_GREEN <= s1[15:8];
        O_BLUE <= s1[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// [wbl_monitor.sv]
// Assertion checker for the colour balance lookup stage
`timescale 1ns/100ps
`default_nettype none
module wbl_monitor (
  // Watched ports
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic O_REG_RVALID,
  input wire logic O_LOAD_DONE,
  input wire logic O_PIX_VALID,
  input wire logic I_PIX_READY,
  input wire logic [7:0] O_RED,
  input wire logic O_HSYNC,
  input wire logic O_DE
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);
  // One answer per read, read data stands between reads
  chk_read_answer: assert property (I_REG_RD |=> O_REG_RVALID) else $error("no answer");
  chk_spare_answer: assert property (!I_REG_RD |=> !O_REG_RVALID) else $error("stray answer");
  chk_rdata_stands: assert property (!I_REG_RD |=> $stable(O_REG_RDATA)) else $error("rdata moved");
  // Load completion is sticky and only a last-entry write sets it
  chk_done_sticky: assert property (O_LOAD_DONE |=> O_LOAD_DONE) else $error("done fell");
  chk_done_by_write: assert property (!I_REG_WR |=> $stable(O_LOAD_DONE)) else $error("done moved");
  chk_done_last: assert property ($rose(O_LOAD_DONE) |-> $past(I_REG_ADDR) == 8'hFF) else $error("early");
  // A stalled pixel keeps colour and syncs together
  chk_pix_hold: assert property (O_PIX_VALID && !I_PIX_READY |=> O_PIX_VALID && $stable(O_RED)) else $error("hold");
  chk_sync_hold: assert property (O_PIX_VALID && !I_PIX_READY |=> $stable({O_HSYNC, O_DE})) else $error("sync");
  cover property (I_REG_RD ##1 O_REG_RVALID);
  cover property (O_PIX_VALID && !I_PIX_READY);
  cover property (O_PIX_VALID && I_PIX_READY);
  cover property ($rose(O_LOAD_DONE));
endmodule
bind wbl_top wbl_monitor wbl_monitor_i (.I_CORE_CLK, .I_RST, .I_REG_WR, .I_REG_RD, .I_REG_ADDR, .O_REG_RDATA,
  .O_REG_RVALID, .O_LOAD_DONE, .O_PIX_VALID, .I_PIX_READY, .O_RED, .O_HSYNC, .O_DE);
`default_nettype wire

// [wbl_panel.sv]
// Display panel model that takes pixels promptly, slowly or not at all
`timescale 1ns/100ps
`default_nettype none
module wbl_panel (
  // Clock and pace: 0 stall, 1 slow, 2 prompt
  input wire logic i_clk,
  input wire logic [1:0] i_mode,
  // Accept
  output logic o_ready
);
  logic tick = 1'b0; // Alternates so slow mode takes a pixel every other cycle
  always_ff @(posedge i_clk) begin
    tick <= !tick;
  end
  assign o_ready = i_mode[1] | (i_mode[0] & tick);
endmodule
`default_nettype wire

// [wbl_top_bench.sv]
// Self-checking bench for the colour balance lookup stage
`timescale 1ns/100ps
`default_nettype none
module wbl_top_bench;
  logic clk = 0, rst = 1, wr = 0, rd = 0, pv = 0, hs = 0, vs = 0, de = 0, en = 0, acc = 0, rl = 0;
  logic [7:0] ad = 0, wd = 0, r = 0, g = 0, b = 0, rdat, ro, go, bo;
  logic rv, done, prdy, ov, ohs, ovs, ode, srdy;
  logic [1:0] mode = 2'h2; // Panel pace
  logic [26:0] q[$]; // Expected pixels in order
  int num_errors = 0, compares = 0, cyc = 0;
  always #2.5 clk = ~clk;
  wbl_top wbl_top_i (.I_CORE_CLK(clk), .I_RST(rst), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(ad),
    .I_REG_WDATA(wd), .O_REG_RDATA(rdat), .O_REG_RVALID(rv), .O_LOAD_DONE(done), .I_PIX_VALID(pv),
    .O_PIX_READY(prdy), .I_RED(r), .I_GREEN(g), .I_BLUE(b), .I_HSYNC(hs), .I_VSYNC(vs), .I_DE(de),
    .O_PIX_VALID(ov), .I_PIX_READY(srdy), .O_RED(ro), .O_GREEN(go), .O_BLUE(bo), .O_HSYNC(ohs),
    .O_VSYNC(ovs), .O_DE(ode));
  wbl_panel wbl_panel_i (.i_clk(clk), .i_mode(mode), .o_ready(srdy));
  task chk(input logic [26:0] got, input logic [26:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Table contents: six significant bits, two low bits cleared, a different curve per colour
  function automatic logic [7:0] lut(input int c, input logic [7:0] i, input int gen);
    logic [7:0] v;
    v = ~i + 8'(c * 85) + 8'(gen * 16);
    return {v[7:2], 2'b00};
  endfunction
  // Entry expected once the reload has rewritten red entries 0..31
  function automatic logic [7:0] want(input int c, input logic [7:0] i);
    return lut(c, i, (c == 0 && rl && i < 8'h20) ? 1 : 0);
  endfunction
  // Timeout, input capture, and in-order output compare
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      report_and_stop;
    end
    acc <= pv && prdy;
    if (pv && prdy) q.push_back({hs, vs, de, en ? {want(0, r), want(1, g), want(2, b)} : {r, g, b}});
    if (ov && srdy) chk({ohs, ovs, ode, ro, go, bo}, q.pop_front());
  end
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1; ad = a; wd = d;
    @(negedge clk);
    wr = 0;
  endtask
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    rd = 1; ad = a;
    @(negedge clk);
    rd = 0;
    chk({rv, rdat}, {1'b1, e});
  endtask
  // Sends n pixels, holding each until taken
  task pix(input int n);
    @(negedge clk);
    pv = 1;
    for (int k = 0; k < n; k++) begin
      r = 8'(k * 37); g = 8'(k + 3); b = ~8'(k); {hs, vs, de} = 3'(k);
      do @(negedge clk); while (!acc);
    end
    pv = 0;
  endtask
  task drain;
    repeat (30) @(negedge clk);
    chk(27'(q.size()), 27'h0);
  endtask
  task t_pass;
    rd_reg(8'h2A, 8'h00);
    mode = 2'h1;
    pix(12);
    drain;
    $display("t_pass done");
  endtask
  // Stalled panel backs the FIFO up until it refuses
  task t_fill;
    mode = 2'h0;
    fork
      pix(14);
      begin
        repeat (12) @(negedge clk);
        chk(prdy, 0);
        mode = 2'h2;
      end
    join
    drain;
    $display("t_fill done");
  endtask
  task t_ctrl;
    wr_reg(8'h2A, 8'h0F);
    rd_reg(8'h2A, 8'h00);
    rd_reg(8'h10, 8'h00);
    $display("t_ctrl done");
  endtask
  // Selects table c with the enable and reload bits er
  task page(input int c, input logic [1:0] er);
    wr_reg(8'h2A, {2'(c + 1), er, 4'h0});
  endtask
  // Writes entries 0..n-1 of table c; a write to entry 255 hands the window back
  task fill(input int c, input int gen, input int n);
    for (int i = 0; i < n; i++) wr_reg(8'(i), lut(c, 8'(i), gen));
  endtask
  // Initial load red, green, blue; out-of-order writes refused; remap enabled after the load, then locked writes refused
  task t_red;
    page(0, 2'h0);
    fill(0, 0, 256);
    chk(done, 0);
    rd_reg(8'h2A, 8'h00);
    page(0, 2'h0);
    wr_reg(8'h07, 8'h00);
    rd_reg(8'h07, lut(0, 8'h07, 0));
    rd_reg(8'h00, lut(0, 8'h00, 0));
    rd_reg(8'h2A, lut(0, 8'h2A, 0));
    wr_reg(8'hFF, 8'h00);
    page(1, 2'h0);
    fill(1, 0, 256);
    chk(done, 0);
    page(2, 2'h0);
    fill(2, 0, 256);
    chk(done, 1);
    wr_reg(8'h2A, 8'h20);
    en = 1;
    rd_reg(8'h2A, 8'h20);
    page(0, 2'h2);
    wr_reg(8'h03, 8'h00);
    rd_reg(8'h03, lut(0, 8'h03, 0));
    rd_reg(8'hFF, lut(0, 8'hFF, 0));
    wr_reg(8'hFF, 8'h00);
    rd_reg(8'h2A, 8'h20);
    page(2, 2'h2);
    rd_reg(8'h80, lut(2, 8'h80, 0));
    wr_reg(8'hFF, 8'h00);
    rd_reg(8'hFF, 8'h00);
    mode = 2'h1;
    pix(16);
    drain;
    $display("t_red done");
  endtask
  // Reload permitted: red entries 0..31 change while remap stays on, the rest keep their values
  task t_reload;
    page(0, 2'h3);
    fill(0, 1, 32);
    rd_reg(8'h05, lut(0, 8'h05, 1));
    rd_reg(8'hC8, lut(0, 8'hC8, 0));
    wr_reg(8'hFF, lut(0, 8'hFF, 0));
    rl = 1;
    rd_reg(8'h2A, 8'h30);
    mode = 2'h2;
    pix(16);
    drain;
    $display("t_reload done");
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    t_pass;
    t_fill;
    t_ctrl;
    t_red;
    t_reload;
    report_and_stop;
  end
endmodule
`default_nettype wire
